// ===== logic/rtcia_core.sv
// rtcia_core: host strobe bus, clock space, paged ram, timebase and alarm of the clock core
`timescale 1ns/100ps
`default_nettype none
module rtcia_core #(
   parameter int unsigned ACCESS_DELAY_CYCLES = rtcia_pkg::ACCESS_DELAY_CYCLES,
   parameter int unsigned PAGE_COUNT          = rtcia_pkg::PAGE_COUNT
) (
   // clock, reset and freeze
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   input  wire logic                  clk_en,
   // supply monitor and standby
   input  wire logic                  supply_access_threshold,
   input  wire logic                  stby_n,
   // host strobe bus
   input  wire rtcia_pkg::rtcia_bus_t host_bus,
   output var  logic [7:0]            data_o,
   output var  logic                  data_oe,
   // open-drain interrupt
   output var  logic                  irq_n_o,
   output var  logic                  irq_oe,
   // crystal
   input  wire logic                  xtal_in,
   output var  logic                  xtal_out
);

   localparam int DLY_W = $clog2(ACCESS_DELAY_CYCLES + 1);
   localparam int PG_W  = $clog2(PAGE_COUNT);
   localparam int PS_W  = rtcia_pkg::PRESCALE_BITS;
   localparam int BY_W  = $clog2(rtcia_pkg::PAGE_BYTES);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [DLY_W-1:0]          dly_q;
   logic                      ready_q;
   logic [5:0]                idx_q;
   logic [PG_W-1:0]           page_q;
   logic [7:0]                ctrl_a_q;
   logic [7:0]                ctrl_b_q;
   logic                      af_q;
   logic                      xtal_q;
   logic [PS_W-1:0]           presc_q;
   logic                      wr_low_q;
   logic                      wrtc_q;
   logic                      wxram_q;
   logic [5:0]                waddr_q;
   logic [7:0]                wdata_q;
   logic                      rd_act_q;
   logic                      rd_c_q;
   logic                      rd_af_q;
   logic [7:0]                data_q;
   logic                      upd_q;
   rtcia_pkg::rtcia_time_t    time_q;
   rtcia_pkg::rtcia_time_t    vis_q;
   rtcia_pkg::rtcia_time_t    time_nxt;
   logic                      alarm_hit;
   logic [7:0]                clock_ram_q [rtcia_pkg::CLOCK_SPACE_BYTES];
   logic [7:0]                ext_ram_q [PAGE_COUNT * rtcia_pkg::PAGE_BYTES];

   // ------------------------------------------------------------------
   // oscillator control and access gate
   // ------------------------------------------------------------------
   logic osc_run;
   logic osc_hold;
   logic bus_ok;
   logic rtc_sel;
   logic ext_ram_select_n_sel;
   logic rd_act;

   // decode of the oscillator field of the first control register
   assign osc_run  = ctrl_a_q[rtcia_pkg::A_OSC_HI:rtcia_pkg::A_OSC_LO]
                     == rtcia_pkg::OSC_RUN;
   assign osc_hold = ctrl_a_q[rtcia_pkg::A_OSC_HI:rtcia_pkg::A_OSC_HI-1]
                     == rtcia_pkg::OSC_HOLD;

   // low supply or standby forces both selects inactive
   assign bus_ok   = supply_access_threshold & stby_n & ready_q;
   assign rtc_sel  = bus_ok & ~host_bus.rtc_sel_n;
   assign ext_ram_select_n_sel = bus_ok & ~host_bus.ext_ram_select_n;
   assign rd_act   = ~host_bus.rd_n & (rtc_sel | ext_ram_select_n_sel);

   // power-up lockout; once granted, access stays until supply drops again
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dly_q   <= '0;
         ready_q <= 1'b0;
      end else if (clk_en) begin
         if (!supply_access_threshold) begin
            dly_q   <= '0;
            ready_q <= 1'b0;
         end else if (!ready_q) begin
            if (dly_q != DLY_W'(ACCESS_DELAY_CYCLES)) begin
               dly_q <= dly_q + 1'b1;
            end else if (osc_run) begin
               ready_q <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // timebase
   // ------------------------------------------------------------------
   logic xtal_rise;
   logic sec_tick;
   logic tick_adv;

   assign xtal_rise = xtal_in & ~xtal_q;
   assign sec_tick  = osc_run & xtal_rise & (&presc_q);
   assign tick_adv  = sec_tick & ~ctrl_b_q[rtcia_pkg::B_SET_BIT];
   // the inverter stays quiet while the oscillator is off
   assign xtal_out  = (osc_run | osc_hold) & ~xtal_in;

   // binary up-counting chain, held clear in the hold pattern
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         xtal_q  <= 1'b0;
         presc_q <= '0;
      end else if (clk_en) begin
         xtal_q <= xtal_in;
         if (osc_hold) begin
            presc_q <= '0;
         end else if (osc_run && xtal_rise) begin
            presc_q <= presc_q + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // write strobe: data taken when the write strobe returns high
   // ------------------------------------------------------------------
   logic       wr_stb;
   logic       w_dat;
   logic       w_time;
   logic       w_ram;
   logic [7:0] wval;

   // capture select, address and data while the strobe is low
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_low_q <= 1'b0;
         wrtc_q   <= 1'b0;
         wxram_q  <= 1'b0;
         waddr_q  <= '0;
         wdata_q  <= '0;
      end else if (clk_en) begin
         wr_low_q <= ~host_bus.wr_n;
         if (!host_bus.wr_n) begin
            wrtc_q  <= rtc_sel;
            wxram_q <= ext_ram_select_n_sel;
            waddr_q <= host_bus.addr;
            wdata_q <= host_bus.data;
         end
      end
   end

   // a cycle cut short by standby or low supply never commits
   assign wr_stb = host_bus.wr_n & wr_low_q & bus_ok;
   assign w_dat  = wr_stb & wrtc_q & waddr_q[rtcia_pkg::ADDR_SEL_BIT];
   assign w_time = w_dat & (idx_q < 6'(rtcia_pkg::TIME_BYTES));
   assign w_ram  = w_dat & (idx_q > rtcia_pkg::IDX_STAT_D);
   // seconds bit 7 cannot be written
   assign wval   = (idx_q == rtcia_pkg::IDX_SEC) ? (wdata_q & rtcia_pkg::RO_BIT7_MASK)
                   : wdata_q;

   // ------------------------------------------------------------------
   // index, page and control registers
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_q  <= '0;
         page_q <= '0;
      end else if (clk_en && wr_stb) begin
         if (wrtc_q && !waddr_q[rtcia_pkg::ADDR_SEL_BIT]) begin
            idx_q <= wdata_q[5:0];
         end
         // only address bit 5 decodes, so 31 aliases reach the page register
         if (wxram_q && waddr_q[rtcia_pkg::ADDR_PAGE_BIT]) begin
            page_q <= wdata_q[PG_W-1:0];
         end
      end
   end

   // flags and status registers take no write at all
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_a_q <= rtcia_pkg::CTRL_A_RESET;
         ctrl_b_q <= rtcia_pkg::CTRL_B_RESET;
      end else if (clk_en && w_dat) begin
         if (idx_q == rtcia_pkg::IDX_CTRL_A) begin
            ctrl_a_q <= wdata_q & rtcia_pkg::RO_BIT7_MASK;
         end
         if (idx_q == rtcia_pkg::IDX_CTRL_B) begin
            ctrl_b_q <= wdata_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // time bytes: counting copy and host-visible copy
   // ------------------------------------------------------------------
   rtcia_time_adv u_adv (
      .cur       (time_q),
      .fmt       ({ctrl_b_q[rtcia_pkg::B_DM_BIT], ctrl_b_q[rtcia_pkg::B_HR24_BIT]}),
      .nxt       (time_nxt),
      .alarm_hit (alarm_hit)
   );

   // the count copy advances; a host write always lands in both copies
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         time_q <= rtcia_pkg::TIME_RESET;
         vis_q  <= rtcia_pkg::TIME_RESET;
         upd_q  <= 1'b0;
      end else if (clk_en) begin
         upd_q <= tick_adv && !w_time;
         if (w_time) begin
            time_q[8*idx_q[3:0] +: 8] <= wval;
            vis_q[8*idx_q[3:0] +: 8]  <= wval;
         end else if (tick_adv) begin
            time_q <= time_nxt;
         end else if (upd_q) begin
            vis_q <= time_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // general ram: clock-space bytes and paged extended ram
   // ------------------------------------------------------------------
   // memories carry no reset; their content is meant to survive it
   always_ff @(posedge core_clk) begin
      if (clk_en && w_ram) begin
         clock_ram_q[idx_q] <= wdata_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clk_en && wr_stb && wxram_q && !waddr_q[rtcia_pkg::ADDR_PAGE_BIT]) begin
         ext_ram_q[{page_q, waddr_q[BY_W-1:0]}] <= wdata_q;
      end
   end

   // ------------------------------------------------------------------
   // alarm flag and interrupt
   // ------------------------------------------------------------------
   logic irq;
   logic c_rd_end;

   assign irq      = af_q & ctrl_b_q[rtcia_pkg::B_AIE_BIT];
   assign c_rd_end = rd_act_q & ~rd_act & rd_c_q;
   assign irq_n_o  = 1'b0;
   // released while supply is low, as the data bus is; xtal_out keeps running
   assign irq_oe   = irq & supply_access_threshold;

   // an event in the clearing cycle wins; only a flag seen by the read is cleared
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         af_q <= 1'b0;
      end else if (clk_en) begin
         if (tick_adv && alarm_hit) begin
            af_q <= 1'b1;
         end else if (c_rd_end && rd_af_q) begin
            af_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // read path: value latched at read start, stable for the whole strobe
   // ------------------------------------------------------------------
   logic [7:0] rd_mux;
   logic [7:0] clk_byte;

   always_comb begin
      unique case (idx_q)
         rtcia_pkg::IDX_CTRL_A: clk_byte = ctrl_a_q;
         rtcia_pkg::IDX_CTRL_B: clk_byte = ctrl_b_q;
         rtcia_pkg::IDX_FLAGS:  clk_byte = (af_q ? rtcia_pkg::AF_MASK : 8'h00)
                                           | (irq ? rtcia_pkg::IRQ_SUMMARY_FLAG_MASK : 8'h00);
         rtcia_pkg::IDX_STAT_D: clk_byte = rtcia_pkg::STAT_D_VALUE;
         default: begin
            if (idx_q < 6'(rtcia_pkg::TIME_BYTES)) begin
               clk_byte = vis_q[8*idx_q[3:0] +: 8];
            end else begin
               clk_byte = clock_ram_q[idx_q];
            end
         end
      endcase
   end

   // space and register picked by selects and address bits
   always_comb begin
      if (rtc_sel) begin
         rd_mux = host_bus.addr[rtcia_pkg::ADDR_SEL_BIT] ? clk_byte
                  : {2'h0, idx_q};
      end else if (host_bus.addr[rtcia_pkg::ADDR_PAGE_BIT]) begin
         rd_mux = 8'(page_q);
      end else begin
         rd_mux = ext_ram_q[{page_q, host_bus.addr[BY_W-1:0]}];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_act_q <= 1'b0;
         rd_c_q   <= 1'b0;
         rd_af_q  <= 1'b0;
         data_q   <= '0;
      end else if (clk_en) begin
         rd_act_q <= rd_act;
         if (rd_act && !rd_act_q) begin
            data_q  <= rd_mux;
            rd_c_q  <= rtc_sel && host_bus.addr[rtcia_pkg::ADDR_SEL_BIT]
                       && idx_q == rtcia_pkg::IDX_FLAGS;
            rd_af_q <= af_q;
         end
      end
   end

   // the bus is driven one cycle after the read is seen, released with it
   assign data_o  = data_q;
   assign data_oe = rd_act_q & rd_act;

endmodule
`default_nettype wire

// ===== logic/rtcia_pkg.sv
// rtcia_pkg: shared constants and types of the indexed-access clock and calendar core
// Summary of operation
// - after supply rises, refuse access 200 ms, then grant only if chain runs
// - supply below threshold: both selects inactive, inputs ignored, outputs released; xtal_out stays driven while the oscillator runs
// - two spaces: clock space on clock select, extended ram on ram select
// - clock space has 64 bytes: 10 time, 4 control, 50 general ram
// - third and fourth control registers are read-only
// - bit 7 of first control register and of seconds byte are read-only
// - clock select with address bit 0 low reaches the index register
// - clock select with address bit 0 high reaches the indexed clock byte
// - ram select with address bit 5 low: bits 0-4 pick byte in page
// - ram select with address bit 5 high reaches the 128-entry page register
// - page register decode uses address bit 5 only, lower bits are aliases
// - all time, calendar, alarm bytes share one binary or bcd format
// - update-inhibit bit set stops time advancing; host sets it while writing
// - 12-hour mode: hour bit 7 means afternoon, lower bits count 1 to 12
// - time bytes always host accessible; counting uses a separate copy
// - once per second advance the time bytes, then compare against alarms
// - seconds, minutes, hours matching alarms raise interrupt when alarm enable set
// - alarm byte with both top bits set matches any value
// - wildcards give hourly, per-minute or per-second alarms as fields allow
// - one-second timebase divided from 32.768 kHz crystal by binary chain
// - alarm flag set on every alarm event regardless of enable
// - interrupt line low while flag and enable set; reading flags clears them
// - control bits 6:4 = 010 runs chain, 11x holds chain, else oscillator off
`default_nettype none
package rtcia_pkg;

   // ------------------------------------------------------------------
   // clock space indices
   // ------------------------------------------------------------------
   localparam logic [5:0] IDX_SEC    = 6'h00;
   localparam logic [5:0] IDX_CTRL_A = 6'h0a;
   localparam logic [5:0] IDX_CTRL_B = 6'h0b;
   localparam logic [5:0] IDX_FLAGS  = 6'h0c;
   localparam logic [5:0] IDX_STAT_D = 6'h0d;
   localparam int         TIME_BYTES = 10;
   localparam int         CLOCK_SPACE_BYTES = 64;
   localparam int         PAGE_COUNT = 128;
   localparam int         PAGE_BYTES = 32;

   // ------------------------------------------------------------------
   // field positions, masks and reset values
   // ------------------------------------------------------------------
   localparam int         ADDR_SEL_BIT  = 0;
   localparam int         ADDR_PAGE_BIT = 5;
   localparam int         A_OSC_HI      = 6;
   localparam int         A_OSC_LO      = 4;
   localparam logic [2:0] OSC_RUN       = 3'h2;
   localparam logic [1:0] OSC_HOLD      = 2'h3;
   localparam int         B_SET_BIT     = 7;
   localparam int         B_AIE_BIT     = 5;
   localparam int         B_DM_BIT      = 2;
   localparam int         B_HR24_BIT    = 1;
   localparam int         HR_PM_BIT     = 7;
   localparam logic [7:0] RO_BIT7_MASK  = 8'h7f;
   localparam logic [7:0] AF_MASK       = 8'h20;
   localparam logic [7:0] IRQ_SUMMARY_FLAG_MASK     = 8'h80;
   localparam logic [7:0] STAT_D_VALUE  = 8'h80;
   localparam logic [7:0] CTRL_A_RESET  = 8'h20;
   localparam logic [7:0] CTRL_B_RESET  = 8'h02;
   localparam logic [1:0] WILDCARD      = 2'h3;

   // ------------------------------------------------------------------
   // field ranges
   // ------------------------------------------------------------------
   localparam logic [7:0]  LO0 = 8'h00;
   localparam logic [7:0]  LO1 = 8'h01;
   localparam logic [7:0]  SEC_MAX = 8'h3b;
   localparam logic [7:0]  HR24_MAX = 8'h17;
   localparam logic [7:0]  HR12_MAX = 8'h0c;
   localparam logic [7:0]  DOW_MAX = 8'h07;
   localparam logic [7:0]  MON_MAX = 8'h0c;
   localparam logic [7:0]  YEAR_MAX = 8'h63;
   localparam logic [7:0]  MON_FEB = 8'h02;
   localparam logic [15:0] MON_30_MASK = 16'h0528;
   localparam logic [7:0]  DAYS_28 = 8'h1c;
   localparam logic [7:0]  DAYS_29 = 8'h1d;
   localparam logic [7:0]  DAYS_30 = 8'h1e;
   localparam logic [7:0]  DAYS_31 = 8'h1f;
   localparam logic [7:0]  BCD_TEN = 8'h0a;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int XTAL_HZ = 32768;
   localparam int PRESCALE_BITS = $clog2(XTAL_HZ);
   localparam int CLK_HZ = 100_000_000;
   localparam int ACCESS_DELAY_MS = 200;
   localparam int ACCESS_DELAY_CYCLES = ACCESS_DELAY_MS * (CLK_HZ / 1000);

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] year, mon, date, dow, hr_alm, hr, min_alm, min, sec_alm, sec;
   } rtcia_time_t;
   localparam rtcia_time_t TIME_RESET = '0;

   typedef struct packed {
      logic dm;
      logic hr24;
   } rtcia_fmt_t;

   typedef struct packed {
      logic       rd_n;
      logic       wr_n;
      logic       rtc_sel_n;
      logic       ext_ram_select_n;
      logic [5:0] addr;
      logic [7:0] data;
   } rtcia_bus_t;

endpackage
`default_nettype wire

// ===== logic/rtcia_time_adv.sv
// rtcia_time_adv: one-second advance of the time bytes and alarm compare
`timescale 1ns/100ps
`default_nettype none
module rtcia_time_adv (
   // count copy and format
   input  wire rtcia_pkg::rtcia_time_t cur,
   input  wire rtcia_pkg::rtcia_fmt_t  fmt,
   // advanced value and compare
   output var  rtcia_pkg::rtcia_time_t nxt,
   output var  logic                   alarm_hit
);

   function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
      return bcd ? 8'({4'h0, v[7:4]} * rtcia_pkg::BCD_TEN) + {4'h0, v[3:0]} : v;
   endfunction

   function automatic logic [7:0] to_fmt(input logic [7:0] b, input logic bcd);
      return bcd ? {4'(b / rtcia_pkg::BCD_TEN), 4'(b % rtcia_pkg::BCD_TEN)} : b;
   endfunction

   // {wrap, value}; out-of-range values wrap too so a bad write self-heals
   function automatic logic [8:0] step(input logic [7:0] v, lo, hi, input logic bcd);
      logic [7:0] b;
      b = to_bin(v, bcd);
      if (b >= hi) return {1'b1, to_fmt(lo, bcd)};
      return {1'b0, to_fmt(b + 8'h01, bcd)};
   endfunction

   function automatic logic hit(input logic [7:0] v, a);
      return (a[7:6] == rtcia_pkg::WILDCARD) || (a == v);
   endfunction

   // ------------------------------------------------------------------
   // carry chain
   // ------------------------------------------------------------------
   always_comb begin
      logic [8:0] r;
      logic [7:0] mb;
      logic [7:0] yb;
      logic [7:0] mdays;
      logic       day;
      r = '0;
      day = 1'b0;
      mdays = rtcia_pkg::DAYS_31;
      nxt = cur;
      mb = to_bin(cur.mon, fmt.dm);
      yb = to_bin(cur.year, fmt.dm);
      // leap year every fourth year across the two-digit range
      if (mb == rtcia_pkg::MON_FEB) begin
         mdays = (yb[1:0] == 2'h0) ? rtcia_pkg::DAYS_29 : rtcia_pkg::DAYS_28;
      end else if (rtcia_pkg::MON_30_MASK[4'(mb - 8'h01)]) begin
         mdays = rtcia_pkg::DAYS_30;
      end else begin
         mdays = rtcia_pkg::DAYS_31;
      end
      r = step(cur.sec, rtcia_pkg::LO0, rtcia_pkg::SEC_MAX, fmt.dm);
      nxt.sec = r[7:0];
      if (r[8]) begin
         r = step(cur.min, rtcia_pkg::LO0, rtcia_pkg::SEC_MAX, fmt.dm);
         nxt.min = r[7:0];
         if (r[8]) begin
            if (fmt.hr24) begin
               r = step(cur.hr, rtcia_pkg::LO0, rtcia_pkg::HR24_MAX, fmt.dm);
               nxt.hr = r[7:0];
               day = r[8];
            end else begin
               // 11 to 12 flips the half-day; 11 pm to 12 am carries the day
               r = step({1'b0, cur.hr[6:0]}, rtcia_pkg::LO1, rtcia_pkg::HR12_MAX, fmt.dm);
               day = 1'b0;
               if (!r[8] && to_bin(r[7:0], fmt.dm) == rtcia_pkg::HR12_MAX) begin
                  day = cur.hr[rtcia_pkg::HR_PM_BIT];
                  nxt.hr = {~cur.hr[rtcia_pkg::HR_PM_BIT], r[6:0]};
               end else begin
                  nxt.hr = {cur.hr[rtcia_pkg::HR_PM_BIT], r[6:0]};
               end
            end
         end
      end
      if (day) begin
         r = step(cur.dow, rtcia_pkg::LO1, rtcia_pkg::DOW_MAX, fmt.dm);
         nxt.dow = r[7:0];
         r = step(cur.date, rtcia_pkg::LO1, to_fmt(mdays, fmt.dm) == cur.date ?
                  to_bin(cur.date, fmt.dm) : mdays, fmt.dm);
         nxt.date = r[7:0];
         if (r[8]) begin
            r = step(cur.mon, rtcia_pkg::LO1, rtcia_pkg::MON_MAX, fmt.dm);
            nxt.mon = r[7:0];
            if (r[8]) begin
               r = step(cur.year, rtcia_pkg::LO0, rtcia_pkg::YEAR_MAX, fmt.dm);
               nxt.year = r[7:0];
            end
         end
      end
   end

   // compare the freshly advanced time against the three alarm bytes
   assign alarm_hit = hit(nxt.sec, cur.sec_alm) & hit(nxt.min, cur.min_alm)
                      & hit(nxt.hr, cur.hr_alm);

endmodule
`default_nettype wire

// ===== testbench/rtcia_core_sva.sv
// rtcia_core_sva: port-level assertions of the clock core
`timescale 1ns/100ps
`default_nettype none
module rtcia_chk (
   // core clock, reset and gating inputs
   input wire logic                  core_clk,
   input wire logic                  reset_n,
   input wire logic                  clk_en,
   input wire logic                  supply_access_threshold,
   input wire logic                  stby_n,
   // host side
   input wire rtcia_pkg::rtcia_bus_t host_bus,
   input wire logic [7:0]            data_o,
   input wire logic                  data_oe,
   // interrupt and crystal
   input wire logic                  irq_n_o,
   input wire logic                  irq_oe,
   input wire logic                  xtal_in,
   input wire logic                  xtal_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // first cycle of a read strobe; the answer may only come one edge later
   sequence rd_first; host_bus.rd_n ##1 !host_bus.rd_n; endsequence
   wire logic sel     = !host_bus.rtc_sel_n || !host_bus.ext_ram_select_n;
   wire logic gate_ok = supply_access_threshold && stby_n;
   oe_gate_a: assert property (data_oe |-> $past(gate_ok))
      else $error("data driven while gated");
   oe_strobe_a: assert property (data_oe |-> !host_bus.rd_n && sel)
      else $error("data driven without read select");
   oe_late_a: assert property (rd_first |-> !data_oe)
      else $error("data driven too early");
   rd_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_o))
      else $error("read data moved");
   lock_rst_a: assert property ($rose(reset_n) |-> !data_oe [*8])
      else $error("access during lockout");
   lock_sup_a: assert property ($rose(supply_access_threshold) |-> !data_oe [*8])
      else $error("access after supply rise");
   irq_level_a: assert property (irq_n_o == 1'b0)
      else $error("irq level not low");
   irq_gate_a: assert property (irq_oe |-> supply_access_threshold)
      else $error("irq driven while gated");
   xtal_a: assert property (xtal_out |-> !xtal_in)
      else $error("xtal output not inverse");
endmodule
bind rtcia_core rtcia_chk u_chk (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
   .supply_access_threshold(supply_access_threshold), .stby_n(stby_n),
   .host_bus(host_bus), .data_o(data_o), .data_oe(data_oe), .irq_n_o(irq_n_o),
   .irq_oe(irq_oe), .xtal_in(xtal_in), .xtal_out(xtal_out));
`default_nettype wire

// ===== testbench/rtcia_host.sv
// rtcia_host: host strobe bus model with read and write cycles
`timescale 1ns/100ps
`default_nettype none
module rtcia_host (
   input  wire logic                  core_clk,
   output var  rtcia_pkg::rtcia_bus_t host_bus,
   input  wire logic [7:0]            data_o,
   input  wire logic                  data_oe
);
   initial host_bus = '{1'b1, 1'b1, 1'b1, 1'b1, 6'h00, 8'h00};
   // start a cycle just after an edge; w=1 write, x=1 paged ram
   task automatic go(input logic w, x, input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      host_bus = '{w, !w, x, !x, a, d};
   endtask
   // write strobe one cycle low, select held over the commit edge
   task automatic wr(input logic x, input logic [5:0] a, input logic [7:0] d);
      go(1'b1, x, a, d);
      @(posedge core_clk) #1 host_bus.wr_n = 1'b1;
      @(posedge core_clk) #1 host_bus = '{1'b1, 1'b1, 1'b1, 1'b1, a, ~d};
   endtask
   // read held until the device answers, bounded at four edges
   task automatic rd(input logic x, input logic [5:0] a, output logic [7:0] q,
                     output logic ok);
      ok = 1'b0;
      q = 8'h00;
      go(1'b0, x, a, ~host_bus.data);
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge core_clk);
         ok = (data_oe === 1'b1);
         q = data_o;
      end
      #1 host_bus = '{1'b1, 1'b1, 1'b1, 1'b1, a, ~host_bus.data};
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// tb_top: self-checking bench of the clock core
`timescale 1ns/100ps
`default_nettype none
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %0t %h %h", $time, g, e); end end
module tb_top;
   logic core_clk = 0, reset_n = 0, sup = 1, stby_n = 1, xtal = 0, xt_run = 0, ok, irq_oe;
   logic [7:0] d_o, q;
   logic oe, irq_n;
   rtcia_pkg::rtcia_bus_t bus;
   int bad_count = 0, comparisons = 0, i;
   initial forever #5 core_clk = ~core_clk;
   // crystal stands still unless a tick is wanted
   always @(posedge core_clk) if (xt_run) xtal <= ~xtal;
   rtcia_core #(.ACCESS_DELAY_CYCLES(20)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
      .clk_en(1'b1), .supply_access_threshold(sup), .stby_n(stby_n), .host_bus(bus),
      .data_o(d_o), .data_oe(oe), .irq_n_o(irq_n), .irq_oe(irq_oe), .xtal_in(xtal),
      .xtal_out());
   rtcia_host u_host (.core_clk(core_clk), .host_bus(bus), .data_o(d_o), .data_oe(oe));
   task automatic wc(input logic [5:0] a, input logic [7:0] d);
      u_host.wr(1'b0, 6'h00, {2'h0, a});
      u_host.wr(1'b0, 6'h01, d);
   endtask
   task automatic rc(input logic [5:0] a, input logic [7:0] e);
      u_host.wr(1'b0, 6'h00, {2'h0, a});
      u_host.rd(1'b0, 6'h01, q, ok);
      `CK({ok, q}, {1'b1, e})
   endtask
   task results;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      #1 reset_n = 1;
      u_host.rd(1'b0, 6'h00, q, ok); `CK(ok, 1'b0)
      repeat (25) @(posedge core_clk);
      rc(rtcia_pkg::IDX_CTRL_A, rtcia_pkg::CTRL_A_RESET);
      rc(rtcia_pkg::IDX_CTRL_B, rtcia_pkg::CTRL_B_RESET);
      // set, bcd and 12-hour chosen together so all ten bytes are written after, the seconds byte twice
      wc(6'h0b, 8'h84);
      wc(6'h0d, 8'h00); rc(6'h0d, 8'h80);
      wc(6'h0a, 8'hff); rc(6'h0a, 8'h7f); wc(6'h0a, 8'h20);
      wc(6'h00, 8'hff); rc(6'h00, 8'h7f); wc(6'h00, 8'h59);
      wc(6'h3f, 8'h5a); rc(6'h3f, 8'h5a);
      u_host.rd(1'b0, 6'h00, q, ok); `CK(q, 8'h3f)
      $display("test clock space done");
      u_host.wr(1'b1, 6'h3f, 8'h05); u_host.wr(1'b1, 6'h1f, 8'ha5);
      u_host.wr(1'b1, 6'h21, 8'h06); u_host.wr(1'b1, 6'h1f, 8'h3c);
      u_host.rd(1'b1, 6'h20, q, ok); `CK(q, 8'h06)
      u_host.wr(1'b1, 6'h2a, 8'h05); u_host.rd(1'b1, 6'h1f, q, ok); `CK(q, 8'ha5)
      $display("test paged ram done");
      stby_n = 0; u_host.rd(1'b1, 6'h1f, q, ok); `CK(ok, 1'b0)
      stby_n = 1; sup = 0; u_host.rd(1'b1, 6'h1f, q, ok); `CK(ok, 1'b0)
      sup = 1; repeat (25) @(posedge core_clk);
      $display("test gating done");
      wc(6'h01, 8'hc0); wc(6'h03, 8'hff); wc(6'h05, 8'hc5);
      wc(6'h02, 8'h59); wc(6'h04, 8'h11); wc(6'h06, 8'h01);
      wc(6'h07, 8'h31); wc(6'h08, 8'h12); wc(6'h09, 8'h99);
      wc(6'h0b, 8'h24);
      xt_run = 1;
      for (i = 0; i < 70000 && irq_oe !== 1'b1; i++) @(posedge core_clk);
      #1 xt_run = 0;
      `CK(irq_oe, 1'b1)
      if (i < 70000) begin
         rc(6'h0c, 8'ha0);
         rc(6'h00, 8'h00); rc(6'h02, 8'h00);
         rc(6'h04, 8'h92);
         `CK(irq_oe, 1'b0)
      end
      $display("test alarm tick done");
      results();
   end
endmodule
`default_nettype wire
